// ### rtl/boot_strap_sampler.sv
// Functional strap sampler for boot destination and EC interface
module boot_strap_sampler (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic platform_power_good,
  input wire logic resume_well_reset_n,
  input wire logic platform_reset_n,
  input wire logic gen_serial1_out_pin,
  input wire logic gpio_c_pin_5,
  input wire logic flash_serial_out_pin,
  input wire logic flash_serial_in_pin,
  input wire logic flash_quad_line2,
  input wire logic flash_quad_line3,
  input wire logic thermal_alert_n,
  input wire logic sw_boot_dest_we,
  input wire logic sw_boot_dest_wdata,
  input wire logic host_bios_req,
  input wire logic management_engine_flash_req,
  input wire logic lan_flash_req,
  output logic boot_fw_dest_strap,
  output logic boot_dest_sel,
  output logic ec_if_espi_sel,
  output logic boot_strap_pulldown_en,
  output logic ec_strap_pulldown_en,
  output logic flash_strap_pullup_en,
  output logic alert_strap_pulldown_en,
  output logic straps_functional,
  output logic reserved_strap_error,
  output logic bios_to_spi,
  output logic bios_to_lpc,
  output logic engine_flash_grant,
  output logic lan_flash_grant
);
  // Synchronised copies of the pins
  logic pwrok_s;
  logic rsm_s;
  logic plt_s;
  logic boot_pin_s;
  logic ec_pin_s;
  logic alert_pin_s;
  logic [strap_pkg::flash_straps-1:0] flash_pins_s;
  logic pwrok_d, rsm_d;
  logic pwrok_rise, rsm_rise;
  strap_pkg::phase_t boot_phase, ec_phase;

  // All pin inputs cross in one synchroniser bank
  pin_sync #(.width(10)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .async_in({
      platform_power_good,
      resume_well_reset_n,
      platform_reset_n,
      gen_serial1_out_pin,
      gpio_c_pin_5,
      thermal_alert_n,
      flash_quad_line3,
      flash_quad_line2,
      flash_serial_in_pin,
      flash_serial_out_pin}),
    .sync_out({pwrok_s, rsm_s, plt_s, boot_pin_s, ec_pin_s, alert_pin_s, flash_pins_s})
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrok_d <= 1'h0;
      rsm_d <= 1'h0;
    end else if (clk_en) begin
      pwrok_d <= pwrok_s;
      rsm_d <= rsm_s;
    end
  end

  assign pwrok_rise = pwrok_s && !pwrok_d;
  assign rsm_rise = rsm_s && !rsm_d;

  // Boot destination strap phase; re-armed only when power-good drops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_phase <= strap_pkg::st_hold;
    end else if (clk_en) begin
      case (boot_phase)
        strap_pkg::st_hold: if (pwrok_rise) boot_phase <= strap_pkg::st_wait;
        strap_pkg::st_wait: begin
          if (!pwrok_s) boot_phase <= strap_pkg::st_hold;
          else if (plt_s) boot_phase <= strap_pkg::st_done;
        end
        strap_pkg::st_done: if (!pwrok_s) boot_phase <= strap_pkg::st_hold;
        default: boot_phase <= strap_pkg::st_hold;
      endcase
    end
  end

  // EC strap phase; pull-down released once resume reset is high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ec_phase <= strap_pkg::st_hold;
    end else if (clk_en) begin
      case (ec_phase)
        strap_pkg::st_hold: if (rsm_rise) ec_phase <= strap_pkg::st_done;
        strap_pkg::st_done: if (!rsm_s) ec_phase <= strap_pkg::st_hold;
        default: ec_phase <= strap_pkg::st_hold;
      endcase
    end
  end

  // Boot destination latch, software write applies afterwards
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_fw_dest_strap <= strap_pkg::boot_dest_reset;
      boot_dest_sel <= strap_pkg::boot_dest_reset;
    end else if (clk_en) begin
      if (boot_phase == strap_pkg::st_hold && pwrok_rise) begin
        boot_fw_dest_strap <= boot_pin_s;
        boot_dest_sel <= boot_pin_s;
      end else if (sw_boot_dest_we) begin
        boot_dest_sel <= sw_boot_dest_wdata;
      end
    end
  end

  // EC interface and reserved strap check at resume rise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ec_if_espi_sel <= strap_pkg::ec_if_reset;
      reserved_strap_error <= 1'h0;
    end else if (clk_en && ec_phase == strap_pkg::st_hold && rsm_rise) begin
      ec_if_espi_sel <= ec_pin_s;
      reserved_strap_error <= (flash_pins_s != strap_pkg::flash_strap_expect) || alert_pin_s;
    end
  end

  // Pull controls from state, never combinational from pins
  assign boot_strap_pulldown_en = boot_phase != strap_pkg::st_done;
  assign ec_strap_pulldown_en = ec_phase != strap_pkg::st_done;
  assign flash_strap_pullup_en = ec_phase != strap_pkg::st_done;
  assign alert_strap_pulldown_en = ec_phase != strap_pkg::st_done;
  assign straps_functional = boot_phase == strap_pkg::st_done && ec_phase == strap_pkg::st_done;

  // Host BIOS routing; engine and LAN paths ignore destination
  assign bios_to_spi = host_bios_req && boot_dest_sel == strap_pkg::boot_dest_spi;
  assign bios_to_lpc = host_bios_req && boot_dest_sel == strap_pkg::boot_dest_lpc;
  assign engine_flash_grant = management_engine_flash_req;
  assign lan_flash_grant = lan_flash_req;

  a_boot_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && boot_phase == strap_pkg::st_hold && pwrok_rise |=> boot_fw_dest_strap == $past(boot_pin_s))
    else $error("boot strap not latched");
  a_sw_override: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && sw_boot_dest_we && !(boot_phase == strap_pkg::st_hold && pwrok_rise)
    |=> boot_dest_sel == $past(sw_boot_dest_wdata))
    else $error("software destination not applied");
  a_boot_pull: assert property (@(posedge sys_clk) disable iff (!arst_n)
    boot_phase == strap_pkg::st_done |-> !boot_strap_pulldown_en)
    else $error("boot pull-down still on");
  a_lan_grant: assert property (@(posedge sys_clk) disable iff (!arst_n)
    lan_flash_grant == lan_flash_req && engine_flash_grant == management_engine_flash_req)
    else $error("flash grant altered");
  a_ec_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && ec_phase == strap_pkg::st_hold && rsm_rise |=> ec_if_espi_sel == $past(ec_pin_s) ##0 !ec_strap_pulldown_en)
    else $error("ec strap not latched");
  a_ec_pull: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(ec_strap_pulldown_en) |-> $past(rsm_s))
    else $error("ec pull-down off in reset");
  a_flash_pull: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !rsm_s && !rsm_d |-> flash_strap_pullup_en && alert_strap_pulldown_en)
    else $error("reserved pulls off in reset");
  a_ec_frozen: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ec_phase == strap_pkg::st_done ##1 ec_phase == strap_pkg::st_done |-> $stable(ec_if_espi_sel))
    else $error("ec strap changed after latch");
  a_functional: assert property (@(posedge sys_clk) disable iff (!arst_n)
    straps_functional |-> !ec_strap_pulldown_en && !boot_strap_pulldown_en)
    else $error("pin functional while pulled");
  // Pulls may only drop once the owning reset is seen released
  a_boot_pull_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(boot_strap_pulldown_en) |-> $past(plt_s) && $past(pwrok_s))
    else $error("boot pull-down dropped in reset");
  a_boot_pull_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pwrok_s && !pwrok_d |-> boot_strap_pulldown_en)
    else $error("boot pull-down off before sampling");
  a_boot_frozen: assert property (@(posedge sys_clk) disable iff (!arst_n)
    boot_phase != strap_pkg::st_hold |=> $stable(boot_fw_dest_strap))
    else $error("boot strap changed after latch");
  a_sel_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !sw_boot_dest_we && !(boot_phase == strap_pkg::st_hold && pwrok_rise)
    |=> $stable(boot_dest_sel))
    else $error("boot destination changed unasked");
  a_reserved_chk: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && ec_phase == strap_pkg::st_hold && rsm_rise
    |=> reserved_strap_error == ($past(flash_pins_s) != strap_pkg::flash_strap_expect || $past(alert_pin_s)))
    else $error("reserved strap check wrong");
  a_reserved_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ec_phase != strap_pkg::st_hold |=> $stable(reserved_strap_error))
    else $error("reserved flag changed after latch");
  a_bios_route: assert property (@(posedge sys_clk) disable iff (!arst_n)
    bios_to_lpc == (host_bios_req && boot_dest_sel) && bios_to_spi == (host_bios_req && !boot_dest_sel))
    else $error("host firmware access misrouted");
  a_clk_freeze: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !clk_en |=> $stable(boot_phase) && $stable(ec_phase) && $stable(boot_fw_dest_strap)
    && $stable(boot_dest_sel) && $stable(ec_if_espi_sel) && $stable(reserved_strap_error))
    else $error("state moved with clock disabled");
  a_func_after_rst: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(straps_functional) |-> $past(pwrok_s) && $past(rsm_s))
    else $error("pins functional before resets released");

  c_lpc_boot: cover property (@(posedge sys_clk) boot_phase == strap_pkg::st_done && boot_dest_sel);
  c_sw_write: cover property (@(posedge sys_clk) clk_en && sw_boot_dest_we && boot_phase == strap_pkg::st_done);
  c_espi: cover property (@(posedge sys_clk) ec_phase == strap_pkg::st_done && ec_if_espi_sel);
  c_bad_strap: cover property (@(posedge sys_clk) reserved_strap_error);
  c_all_done: cover property (@(posedge sys_clk) straps_functional);
endmodule

// ### rtl/pin_sync.sv
// Two-stage synchroniser for asynchronous level inputs
module pin_sync #(
  parameter int width = 1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1;

  // First stage is read only by the second stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ### rtl/strap_pkg.sv
// Constants and types shared by the strap sampler files
package strap_pkg;
  localparam logic boot_dest_reset = 1'h0;
  localparam logic ec_if_reset = 1'h0;
  localparam int boot_dest_cfg_offset = 32'hbc;
  localparam int boot_dest_cfg_bit = 6;
  localparam int sync_stages = 2;
  localparam int flash_straps = 4;
  localparam logic [3:0] flash_strap_expect = 4'hf;
  localparam logic boot_dest_spi = 1'h0;
  localparam logic boot_dest_lpc = 1'h1;
  localparam logic ec_if_lpc = 1'h0;
  localparam logic ec_if_espi = 1'h1;
  typedef enum logic [2:0] {
    st_hold = 3'h1,
    st_wait = 3'h2,
    st_done = 3'h4
  } phase_t;
endpackage

// ### test/strap_board.sv
// Board strap resistors and drivers seen by the strap sampler
module strap_board (
  input wire logic sys_clk,
  input wire logic [6:0] drv_en,
  input wire logic [6:0] drv_val,
  input wire logic [6:0] pull_on,
  output logic [6:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] pull_lvl = 7'h3c;
  logic flip = 1'h0;
  // Floating pins wander, so a stale level never passes as sampled
  always @(posedge sys_clk) flip <= ~flip;
  // Board drive wins; then the on-chip pull
  assign pin = (drv_en & drv_val) | (~drv_en & pull_on & pull_lvl) | (~drv_en & ~pull_on & {7{flip}});
endmodule

// ### test/tb_top.sv
// Self-checking bench for the boot strap sampler
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, arst_n = 1'h0, clk_en = 1'h1, platform_power_good = 1'h0, resume_well_reset_n = 1'h0;
  logic platform_reset_n = 1'h0, sw_boot_dest_we = 1'h0, sw_boot_dest_wdata = 1'h0, host_bios_req = 1'h0;
  logic management_engine_flash_req = 1'h0, lan_flash_req = 1'h0;
  logic gen_serial1_out_pin, gpio_c_pin_5, flash_serial_out_pin, flash_serial_in_pin, flash_quad_line2;
  logic flash_quad_line3, thermal_alert_n, boot_fw_dest_strap, boot_dest_sel, ec_if_espi_sel;
  logic boot_strap_pulldown_en, ec_strap_pulldown_en, flash_strap_pullup_en, alert_strap_pulldown_en;
  logic straps_functional, reserved_strap_error, bios_to_spi, bios_to_lpc, engine_flash_grant, lan_flash_grant;
  logic [6:0] drv_en = 7'h00, drv_val = 7'h00, pin;
  logic b, e;
  int fail_count = 0, n_checks = 0, bad;
  int m_boot = 0, m_sel = 0, m_ec = 0;
  int model_q[$];
  boot_strap_sampler uut (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .platform_power_good(platform_power_good),
    .resume_well_reset_n(resume_well_reset_n),
    .platform_reset_n(platform_reset_n),
    .gen_serial1_out_pin(gen_serial1_out_pin),
    .gpio_c_pin_5(gpio_c_pin_5),
    .flash_serial_out_pin(flash_serial_out_pin),
    .flash_serial_in_pin(flash_serial_in_pin),
    .flash_quad_line2(flash_quad_line2),
    .flash_quad_line3(flash_quad_line3),
    .thermal_alert_n(thermal_alert_n),
    .sw_boot_dest_we(sw_boot_dest_we),
    .sw_boot_dest_wdata(sw_boot_dest_wdata),
    .host_bios_req(host_bios_req),
    .management_engine_flash_req(management_engine_flash_req),
    .lan_flash_req(lan_flash_req),
    .boot_fw_dest_strap(boot_fw_dest_strap),
    .boot_dest_sel(boot_dest_sel),
    .ec_if_espi_sel(ec_if_espi_sel),
    .boot_strap_pulldown_en(boot_strap_pulldown_en),
    .ec_strap_pulldown_en(ec_strap_pulldown_en),
    .flash_strap_pullup_en(flash_strap_pullup_en),
    .alert_strap_pulldown_en(alert_strap_pulldown_en),
    .straps_functional(straps_functional),
    .reserved_strap_error(reserved_strap_error),
    .bios_to_spi(bios_to_spi),
    .bios_to_lpc(bios_to_lpc),
    .engine_flash_grant(engine_flash_grant),
    .lan_flash_grant(lan_flash_grant)
  );
  strap_board board (.sys_clk(sys_clk), .drv_en(drv_en), .drv_val(drv_val), .pin(pin),
    .pull_on({alert_strap_pulldown_en, {4{flash_strap_pullup_en}}, ec_strap_pulldown_en, boot_strap_pulldown_en}));
  assign {thermal_alert_n, flash_quad_line3, flash_quad_line2, flash_serial_in_pin} = pin[6:3];
  assign {flash_serial_out_pin, gpio_c_pin_5, gen_serial1_out_pin} = pin[2:0];
  task automatic check(input logic seen, input logic want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error %0t: seen %b want %b", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Settled strap level: board drive wins, else the on-chip pull
  function automatic int strap_lvl(input int i, input int pull_hi);
    return drv_en[i] ? int'(drv_val[i]) : pull_hi;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial forever #2.5 sys_clk = ~sys_clk;
  // Whole run needs about 416 cycles; about forty-eight times that is allowed
  initial begin
    #100us;
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h4dcf3cf0));
    tick(16);
    arst_n = 1'h1;
    tick(1);
    check(boot_strap_pulldown_en & ec_strap_pulldown_en & flash_strap_pullup_en, 1'h1);
    check(straps_functional | boot_dest_sel | ec_if_espi_sel, 1'h0);
    for (int t = 0; t < 6; t++) begin
      b = 1'($urandom);
      e = 1'($urandom);
      bad = t % 3;
      {platform_power_good, resume_well_reset_n, platform_reset_n} = 3'h0;
      drv_en = 7'h00;
      tick(8);
      check(alert_strap_pulldown_en & flash_strap_pullup_en & ec_strap_pulldown_en, 1'h1);
      // A low EC strap is left to the on-chip pull-down
      drv_en = {bad == 2, 1'h0, bad == 1, 2'h0, e, 1'h1};
      drv_val = {1'h1, 1'h0, 1'h0, 2'h0, 1'h1, b};
      model_q.push_back(strap_lvl(1, 0));
      model_q.push_back((strap_lvl(2, 1) + strap_lvl(3, 1) + strap_lvl(4, 1) + strap_lvl(5, 1) != 4) || strap_lvl(6, 0) != 0);
      tick(6);
      resume_well_reset_n = 1'h1;
      tick(6);
      m_ec = model_q.pop_front();
      check(ec_if_espi_sel, 1'(m_ec));
      check(ec_strap_pulldown_en, 1'h0);
      check(reserved_strap_error, 1'(model_q.pop_front()));
      m_boot = strap_lvl(0, 0);
      m_sel = m_boot;
      platform_power_good = 1'h1;
      tick(6);
      check(boot_fw_dest_strap, 1'(m_boot));
      check(boot_dest_sel, 1'(m_sel));
      check(boot_strap_pulldown_en, 1'h1);
      drv_en = 7'h00;
      platform_reset_n = 1'h1;
      tick(6);
      check(boot_strap_pulldown_en, 1'h0);
      check(straps_functional, 1'h1);
      tick(20);
      check(boot_fw_dest_strap, 1'(m_boot));
      check(ec_if_espi_sel, 1'(m_ec));
      sw_boot_dest_we = 1'h1;
      sw_boot_dest_wdata = ~b;
      m_sel = int'(sw_boot_dest_wdata);
      tick(1);
      sw_boot_dest_we = 1'h0;
      tick(1);
      check(boot_dest_sel, 1'(m_sel));
      check(boot_fw_dest_strap, 1'(m_boot));
      // A write offered while the clock is disabled must be lost
      clk_en = 1'h0;
      sw_boot_dest_we = 1'h1;
      sw_boot_dest_wdata = b;
      tick(3);
      {clk_en, sw_boot_dest_we} = 2'h2;
      tick(1);
      check(boot_dest_sel, 1'(m_sel));
      for (int k = 0; k < 8; k++) begin
        {host_bios_req, management_engine_flash_req, lan_flash_req} = 3'(k);
        tick(1);
        check(bios_to_lpc, k[2] && m_sel == 1);
        check(bios_to_spi, k[2] && m_sel == 0);
        check(engine_flash_grant, k[1]);
        check(lan_flash_grant, k[0]);
      end
      $display("Test %0d done, %0d mismatches", t, fail_count);
    end
    // Mid-run reset with power-good still high
    arst_n = 1'h0;
    tick(2);
    arst_n = 1'h1;
    tick(1);
    check(boot_strap_pulldown_en & ec_strap_pulldown_en & alert_strap_pulldown_en, 1'h1);
    check(boot_fw_dest_strap | boot_dest_sel | reserved_strap_error, 1'h0);
    $display("Reset test done, %0d mismatches", fail_count);
    stop_test();
  end
endmodule
